// ### verilog/omlp_pkg.sv
// Constants for the OR / move / load-pointer execution unit.
// Assumes a single core clock and a four-phase instruction cycle.
package omlp_pkg;
  // Instruction cycle phases, one clock each
  typedef enum logic [1:0] {
    OMLP_Q1 = 2'b00,
    OMLP_Q2 = 2'b01,
    OMLP_Q3 = 2'b10,
    OMLP_Q4 = 2'b11
  } omlp_phase_t;

  localparam int unsigned IW = 16;
  localparam int unsigned DW = 8;
  localparam int unsigned AW = 12;
  localparam int unsigned RW = 4;

  // Opcode fields
  localparam logic [7:0] OPC_OR_LIT    = 8'h09;
  localparam logic [5:0] OPC_OR_FILE   = 6'h04;
  localparam logic [5:0] OPC_MOVE_FILE = 6'h14;
  localparam logic [7:0] OPC_LOAD_PTR  = 8'hee;
  localparam logic [1:0] PTR_SEL_MAX   = 2'h2;
  localparam int unsigned DEST_BIT     = 9;
  localparam int unsigned BANK_BIT     = 8;
  localparam int unsigned SEL_LSB      = 4;

  // Access bank split and pages
  localparam logic [7:0] ACC_SPLIT     = 8'h5f;
  localparam logic [3:0] ACC_LOW_PAGE  = 4'h0;
  localparam logic [3:0] ACC_HIGH_PAGE = 4'hf;

  // Software register indexes
  localparam logic [RW-1:0] REG_ACC    = 4'h0;
  localparam logic [RW-1:0] REG_BANK   = 4'h1;
  localparam logic [RW-1:0] REG_FLAGS  = 4'h2;
  localparam logic [RW-1:0] REG_CTRL   = 4'h3;
  localparam logic [RW-1:0] REG_PTR0L  = 4'h4;
  localparam logic [RW-1:0] REG_PTR2H  = 4'h9;
  localparam logic [RW-1:0] REG_INFO   = 4'ha;

  // Field positions
  localparam int unsigned FLAG_N       = 4;
  localparam int unsigned FLAG_Z       = 2;
  localparam int unsigned CTRL_EXT     = 0;
  localparam int unsigned CTRL_ILL_CLR = 1;
  localparam int unsigned INFO_ILL     = 0;
  localparam int unsigned INFO_PEND    = 1;

  localparam logic [DW-1:0] RST_BYTE   = 8'h00;
  localparam logic [3:0]    RST_NIB    = 4'h0;
endpackage

// ### verilog/omlp_exec.sv
// Execution unit for OR-literal, OR-file, move-file and load-pointer.
// Assumes program memory and data memory on ref_clk; data memory answers
// a read in the clock after its read strobe.
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/10ps
module omlp_exec (
  input  wire logic                    ref_clk,
  input  wire logic                    rst_b,
  input  wire logic [omlp_pkg::IW-1:0] instr_word,
  input  wire logic                    instr_valid,
  output logic                         instr_ready,
  output logic [omlp_pkg::AW-1:0]      dmem_addr_q,
  output logic                         dmem_rd_q,
  input  wire logic [omlp_pkg::DW-1:0] dmem_rdata,
  output logic                         dmem_wr_q,
  output logic [omlp_pkg::DW-1:0]      dmem_wdata_q,
  input  wire logic [omlp_pkg::RW-1:0] sw_addr,
  input  wire logic [omlp_pkg::DW-1:0] sw_wdata,
  input  wire logic                    sw_wr,
  input  wire logic                    sw_rd,
  output logic [omlp_pkg::DW-1:0]      sw_rdata_q
);
  import omlp_pkg::*;

  omlp_phase_t     phase_q;
  logic [IW-1:0]   ir_q;
  logic            live_q;
  logic            second_q;
  logic            pend_q;
  logic [1:0]      sel_q;
  logic [DW-1:0]   acc_q;
  logic [3:0]      bank_q;
  logic            neg_q;
  logic            zero_q;
  logic            ext_q;
  logic            ill_q;
  logic [3:0]      ptr_hi_q [3];
  logic [DW-1:0]   ptr_lo_q [3];
  logic            take;
  logic            commit;
  logic            is_orl;
  logic            is_orf;
  logic            is_mov;
  logic            is_lp1;
  logic            is_lp2;
  logic            is_bad;
  logic            dest_file;
  logic [DW-1:0]   result;
  logic [AW-1:0]   f_addr;

  // Resolves the 8-bit file field to a data space address
  function automatic logic [AW-1:0] file_addr(input logic [DW-1:0] f,
                                              input logic          banked,
                                              input logic [3:0]    bank,
                                              input logic          ext,
                                              input logic [AW-1:0] base);
    if (banked) begin
      file_addr = {bank, f};
    end else if (ext && f <= ACC_SPLIT) begin
      file_addr = AW'(base + {4'h0, f});
    end else if (f <= ACC_SPLIT) begin
      file_addr = {ACC_LOW_PAGE, f};
    end else begin
      file_addr = {ACC_HIGH_PAGE, f};
    end
  endfunction

  // Places N and Z at their register positions; the other bits read 0
  function automatic logic [DW-1:0] flag_byte(input logic n,
                                              input logic z);
    flag_byte         = RST_BYTE;
    flag_byte[FLAG_N] = n;
    flag_byte[FLAG_Z] = z;
  endfunction

  // Phase sequencer; runs freely so every cycle is four clocks
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_q <= OMLP_Q1;
    end else begin
      case (phase_q)
        OMLP_Q1: phase_q <= OMLP_Q2;
        OMLP_Q2: phase_q <= OMLP_Q3;
        OMLP_Q3: phase_q <= OMLP_Q4;
        OMLP_Q4: phase_q <= OMLP_Q1;
        default: phase_q <= OMLP_Q1;
      endcase
    end
  end

  assign instr_ready = (phase_q == OMLP_Q1);
  assign take        = instr_ready && instr_valid;
  assign commit      = live_q && (phase_q == OMLP_Q4);

  // Fetch: a word is only accepted in Q1
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ir_q     <= {IW{1'b0}};
      live_q   <= 1'b0;
      second_q <= 1'b0;
    end else if (phase_q == OMLP_Q1) begin
      live_q   <= take;
      second_q <= take && pend_q;
      if (take) begin
        ir_q <= instr_word;
      end
    end
  end

  // Decode
  assign is_orl    = live_q && !second_q && ir_q[15:8] == OPC_OR_LIT;
  assign is_orf    = live_q && !second_q && ir_q[15:10] == OPC_OR_FILE;
  assign is_mov    = live_q && !second_q && ir_q[15:10] == OPC_MOVE_FILE;
  assign is_lp1    = live_q && !second_q && ir_q[15:8] == OPC_LOAD_PTR
                     && ir_q[SEL_LSB+1:SEL_LSB] <= PTR_SEL_MAX;
  assign is_lp2    = live_q && second_q;
  assign is_bad    = live_q && !(is_orl || is_orf || is_mov || is_lp1 || is_lp2);
  assign dest_file = ir_q[DEST_BIT];
  assign f_addr    = file_addr(ir_q[7:0], ir_q[BANK_BIT], bank_q, ext_q,
                               {ptr_hi_q[2], ptr_lo_q[2]});

  // Operand arrives in Q4, the clock after the read strobe
  always_comb begin
    if (is_orl) begin
      result = acc_q | ir_q[7:0];
    end else if (is_orf) begin
      result = acc_q | dmem_rdata;
    end else begin
      result = dmem_rdata;
    end
  end

  // Data memory read in Q3 with the address resolved in Q2
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dmem_addr_q <= {AW{1'b0}};
      dmem_rd_q   <= 1'b0;
    end else begin
      dmem_rd_q <= (phase_q == OMLP_Q2) && (is_orf || is_mov);
      if (phase_q == OMLP_Q2) begin
        dmem_addr_q <= f_addr;
      end
    end
  end

  // File write-back; the strobe is registered on the edge after Q4, and the memory takes it on the edge that ends the next Q1
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dmem_wr_q    <= 1'b0;
      dmem_wdata_q <= RST_BYTE;
    end else begin
      dmem_wr_q <= commit && (is_orf || is_mov) && dest_file;
      if (commit) begin
        dmem_wdata_q <= result;
      end
    end
  end

  // Accumulator; a core write wins over a software write in the same clock
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_q <= RST_BYTE;
    end else if (commit && (is_orl || ((is_orf || is_mov) && !dest_file))) begin
      acc_q <= result;
    end else if (sw_wr && sw_addr == REG_ACC) begin
      acc_q <= sw_wdata;
    end
  end

  // Negative and zero flags; load-pointer leaves them alone
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      neg_q  <= 1'b0;
      zero_q <= 1'b0;
    end else if (commit && (is_orl || is_orf || is_mov)) begin
      neg_q  <= result[DW-1];
      zero_q <= (result == RST_BYTE);
    end else if (sw_wr && sw_addr == REG_FLAGS) begin
      neg_q  <= sw_wdata[FLAG_N];
      zero_q <= sw_wdata[FLAG_Z];
    end
  end

  // Pointers: high nibble in the first cycle, low byte in the second
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ptr_hi_q <= '{default: RST_NIB};
      ptr_lo_q <= '{default: RST_BYTE};
      pend_q   <= 1'b0;
      sel_q    <= 2'h0;
    end else begin
      if (commit && is_lp1) begin
        ptr_hi_q[ir_q[SEL_LSB+1:SEL_LSB]] <= ir_q[3:0];
        sel_q  <= ir_q[SEL_LSB+1:SEL_LSB];
        pend_q <= 1'b1;
      end else if (commit && is_lp2) begin
        ptr_lo_q[sel_q] <= ir_q[7:0];
        pend_q <= 1'b0;
      end else if (sw_wr && sw_addr >= REG_PTR0L && sw_addr <= REG_PTR2H) begin
        if (sw_addr[0]) begin
          ptr_hi_q[2'((sw_addr - REG_PTR0L) >> 1)] <= sw_wdata[3:0];
        end else begin
          ptr_lo_q[2'((sw_addr - REG_PTR0L) >> 1)] <= sw_wdata;
        end
      end
    end
  end

  // Bank select, extended-set enable, sticky unknown-opcode flag (set wins)
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      bank_q <= RST_NIB;
      ext_q  <= 1'b0;
      ill_q  <= 1'b0;
    end else begin
      if (sw_wr && sw_addr == REG_BANK) begin
        bank_q <= sw_wdata[3:0];
      end
      if (sw_wr && sw_addr == REG_CTRL) begin
        ext_q <= sw_wdata[CTRL_EXT];
      end
      if (commit && is_bad) begin
        ill_q <= 1'b1;
      end else if (sw_wr && sw_addr == REG_CTRL && sw_wdata[CTRL_ILL_CLR]) begin
        ill_q <= 1'b0;
      end
    end
  end

  // Read data stand for exactly one clock after the strobe
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sw_rdata_q <= RST_BYTE;
    end else if (!sw_rd) begin
      sw_rdata_q <= RST_BYTE;
    end else if (sw_addr == REG_ACC) begin
      sw_rdata_q <= acc_q;
    end else if (sw_addr == REG_BANK) begin
      sw_rdata_q <= {4'h0, bank_q};
    end else if (sw_addr == REG_FLAGS) begin
      sw_rdata_q <= flag_byte(neg_q, zero_q);
    end else if (sw_addr == REG_CTRL) begin
      sw_rdata_q <= DW'({7'h00, ext_q} << CTRL_EXT);
    end else if (sw_addr >= REG_PTR0L && sw_addr <= REG_PTR2H) begin
      sw_rdata_q <= sw_addr[0] ? {4'h0, ptr_hi_q[2'((sw_addr - REG_PTR0L) >> 1)]}
                               : ptr_lo_q[2'((sw_addr - REG_PTR0L) >> 1)];
    end else if (sw_addr == REG_INFO) begin
      sw_rdata_q <= DW'({pend_q, ill_q} << INFO_ILL);
    end else begin
      sw_rdata_q <= RST_BYTE;
    end
  end

  // Checks
  phase_seq_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    phase_q == OMLP_Q1 |=> phase_q == OMLP_Q2 ##1 phase_q == OMLP_Q3 ##1 phase_q == OMLP_Q4)
    else $error("phase order broken");

  or_lit_acc_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    commit && is_orl |=> acc_q == ($past(acc_q) | $past(ir_q[7:0])) && !dmem_wr_q)
    else $error("or literal result wrong");

  nz_flags_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    commit && (is_orf || is_mov) |=> zero_q == ($past(result) == 8'h00)
      && neg_q == $past(result[DW-1]))
    else $error("flag update wrong");

  dest_file_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    commit && (is_orf || is_mov) && dest_file |=> dmem_wr_q
      && dmem_wdata_q == $past(result))
    else $error("file write-back missing");

  mov_to_acc_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    commit && is_mov && !dest_file |=> acc_q == $past(dmem_rdata) && !dmem_wr_q)
    else $error("move to accumulator wrong");

  bank_addr_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    dmem_rd_q && ir_q[BANK_BIT] |-> dmem_addr_q == {$past(bank_q), ir_q[7:0]})
    else $error("banked address wrong");

  access_addr_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    dmem_rd_q && !ir_q[BANK_BIT] && !$past(ext_q) |-> dmem_addr_q[7:0] == ir_q[7:0]
      && dmem_addr_q[11:8] == ((ir_q[7:0] > 8'h5f) ? 4'hf : 4'h0))
    else $error("access bank address wrong");

  indexed_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    dmem_rd_q && !ir_q[BANK_BIT] && $past(ext_q) && ir_q[7:0] <= 8'h5f
      |-> dmem_addr_q == 12'($past({ptr_hi_q[2], ptr_lo_q[2]}) + {4'h0, ir_q[7:0]}))
    else $error("indexed offset address wrong");

  ptr_high_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    commit && is_lp1 && !(sw_wr && sw_addr == REG_FLAGS)
      |=> $stable(neg_q) && $stable(zero_q) && pend_q
      && ptr_hi_q[sel_q] == $past(ir_q[3:0]))
    else $error("pointer high load wrong");

  ptr_low_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    commit && is_lp2 && !(sw_wr && sw_addr == REG_FLAGS)
      |=> !pend_q && ptr_lo_q[sel_q] == $past(ir_q[7:0]) && $stable(zero_q))
    else $error("pointer low load wrong");

  cov_or_file_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
    commit && is_orf && dest_file);
  cov_load_ptr_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
    commit && is_lp1 ##4 commit && is_lp2);
  cov_indexed_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
    dmem_rd_q && is_mov && !ir_q[BANK_BIT] && ext_q);
endmodule // omlp_exec

// ### bench/omlp_dmem_model.sv
// Data memory model that answers the execution unit's read and write strobes.
// Assumes a read strobe one clock ahead of the data and one-clock write pulses.
`timescale 1ns/10ps
module omlp_dmem_model (
  input  wire logic                    ref_clk,
  input  wire logic [omlp_pkg::AW-1:0] dmem_addr_q,
  input  wire logic                    dmem_rd_q,
  input  wire logic                    dmem_wr_q,
  input  wire logic [omlp_pkg::DW-1:0] dmem_wdata_q,
  output logic      [omlp_pkg::DW-1:0] dmem_rdata
);
  import omlp_pkg::*;
  logic [DW-1:0] mem [0:4095];
  initial dmem_rdata = 8'h00;
  // Plain always so the bench may preload cells; outside a read the bus flips
  // every clock, so stale data never passes for an answer
  always @(posedge ref_clk) begin
    if (dmem_rd_q) begin
      dmem_rdata <= mem[dmem_addr_q];
    end else begin
      dmem_rdata <= ~dmem_rdata;
    end
    if (dmem_wr_q) begin
      mem[dmem_addr_q] <= dmem_wdata_q;
    end
  end
endmodule // omlp_dmem_model

// ### bench/tb.sv
// Self-checking bench for the OR / move / load-pointer execution unit.
// Assumes the data memory model beside the unit and the register map of the unit.
`timescale 1ns/10ps
module tb;
  import omlp_pkg::*;
  logic          ref_clk, rst_b, instr_valid, instr_ready, sw_wr, sw_rd;
  logic          dmem_rd_q, dmem_wr_q;
  logic [IW-1:0] instr_word;
  logic [AW-1:0] dmem_addr_q;
  logic [DW-1:0] dmem_rdata, dmem_wdata_q, sw_wdata, sw_rdata_q;
  logic [RW-1:0] sw_addr;
  int            num_errors = 0;
  int            check_count = 0;

  omlp_exec DUT (.ref_clk, .rst_b, .instr_word, .instr_valid, .instr_ready, .dmem_addr_q,
    .dmem_rd_q, .dmem_rdata, .dmem_wr_q, .dmem_wdata_q, .sw_addr, .sw_wdata, .sw_wr,
    .sw_rd, .sw_rdata_q);
  omlp_dmem_model mem_model (.ref_clk, .dmem_addr_q, .dmem_rd_q, .dmem_wr_q,
    .dmem_wdata_q, .dmem_rdata);

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, exp, got);
    end
  endtask

  task automatic wr(input logic [RW-1:0] a, input logic [DW-1:0] d);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge ref_clk);
    sw_wr <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic rrd(input logic [RW-1:0] a, input logic [DW-1:0] e);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge ref_clk);
    sw_rd <= 1'b0;
    @(posedge ref_clk);
    chk($sformatf("register %0d", a), sw_rdata_q, e);
  endtask

  // Holds the word until an edge where the unit was ready; returns on that edge
  task automatic issue(input logic [IW-1:0] w);
    instr_word <= w;
    instr_valid <= 1'b1;
    do @(posedge ref_clk); while (instr_ready !== 1'b1);
  endtask

  task automatic run(input logic [IW-1:0] w, input logic [3:0] erd, input logic ewr);
    logic [3:0] v;
    logic [3:0] r;
    logic       wq;
    issue(w);
    instr_valid <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk);
      v[i] = dmem_rd_q;
      r[i] = instr_ready;
    end
    wq = dmem_wr_q;
    chk("read phase", {4'h0, v}, {4'h0, erd});
    chk("ready phase", {4'h0, r}, 8'h08);
    chk("write strobe", {7'h00, wq}, {7'h00, ewr});
    @(posedge ref_clk);
  endtask

  task automatic test_reset();
    for (int a = 0; a < 16; a++) begin
      rrd(a[3:0], 8'h00);
    end
    wr(4'hc, 8'h55);
    rrd(4'hc, 8'h00);
    $display("reset and map test done");
  endtask

  task automatic test_or_lit();
    wr(REG_ACC, 8'h9a);
    wr(REG_FLAGS, 8'h04);
    run(16'h0935, 4'h0, 1'b0);
    rrd(REG_ACC, 8'hbf);
    rrd(REG_FLAGS, 8'h10);
    wr(REG_ACC, 8'h00);
    run(16'h0900, 4'h0, 1'b0);
    rrd(REG_FLAGS, 8'h04);
    $display("or literal test done");
  endtask

  task automatic test_or_file();
    wr(REG_BANK, 8'h01);
    wr(REG_ACC, 8'h91);
    mem_model.mem[12'h113] = 8'h13;
    run(16'h1113, 4'h2, 1'b0);
    rrd(REG_ACC, 8'h93);
    chk("file 113", mem_model.mem[12'h113], 8'h13);
    mem_model.mem[12'h020] = 8'h40;
    run(16'h1220, 4'h2, 1'b1);
    chk("file 020", mem_model.mem[12'h020], 8'hd3);
    rrd(REG_FLAGS, 8'h10);
    mem_model.mem[12'hf80] = 8'h00;
    run(16'h1280, 4'h2, 1'b1);
    chk("file f80", mem_model.mem[12'hf80], 8'h93);
    $display("or file test done");
  endtask

  task automatic test_move();
    wr(REG_BANK, 8'h0a);
    mem_model.mem[12'haff] = 8'h00;
    run(16'h51ff, 4'h2, 1'b0);
    chk("address page", {4'h0, dmem_addr_q[11:8]}, 8'h0a);
    chk("address byte", dmem_addr_q[7:0], 8'hff);
    rrd(REG_ACC, 8'h00);
    rrd(REG_FLAGS, 8'h04);
    mem_model.mem[12'ha00] = 8'h80;
    run(16'h5300, 4'h2, 1'b1);
    chk("write data", dmem_wdata_q, 8'h80);
    chk("file a00", mem_model.mem[12'ha00], 8'h80);
    rrd(REG_ACC, 8'h00);
    rrd(REG_FLAGS, 8'h10);
    $display("move file test done");
  endtask

  task automatic test_ptr();
    logic [11:0] k;
    logic [1:0]  s;
    wr(REG_FLAGS, 8'h14);
    issue(16'hee23);
    instr_valid <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rrd(REG_INFO, 8'h02);
    rrd(REG_PTR2H, 8'h03);
    rrd(4'h8, 8'h00);
    run(16'hf0ab, 4'h0, 1'b0);
    rrd(4'h8, 8'hab);
    rrd(REG_INFO, 8'h00);
    rrd(REG_FLAGS, 8'h14);
    for (int i = 0; i < 2; i++) begin
      s = i[1:0];
      k = (i == 0) ? 12'hfff : 12'h5c3;
      issue({8'hee, 2'b00, s, k[11:8]});
      run({8'hf0, k[7:0]}, 4'h0, 1'b0);
      rrd(REG_PTR0L + {s, 1'b0}, k[7:0]);
      rrd(REG_PTR0L + {s, 1'b1}, {4'h0, k[11:8]});
    end
    run(16'hee35, 4'h0, 1'b0);
    rrd(REG_INFO, 8'h01);
    rrd(REG_PTR0L, 8'hff);
    wr(REG_CTRL, 8'h02);
    rrd(REG_INFO, 8'h00);
    $display("load pointer test done");
  endtask

  // Pointer 2 holds 3ab from the load-pointer test
  task automatic test_index();
    wr(REG_CTRL, 8'h01);
    wr(REG_ACC, 8'h00);
    mem_model.mem[12'h3b0] = 8'h01;
    mem_model.mem[12'h40a] = 8'h40;
    mem_model.mem[12'hf60] = 8'h20;
    mem_model.mem[12'h005] = 8'h80;
    run(16'h1005, 4'h2, 1'b0);
    rrd(REG_ACC, 8'h01);
    run(16'h105f, 4'h2, 1'b0);
    rrd(REG_ACC, 8'h41);
    run(16'h1060, 4'h2, 1'b0);
    rrd(REG_ACC, 8'h61);
    wr(REG_CTRL, 8'h00);
    run(16'h1005, 4'h2, 1'b0);
    rrd(REG_ACC, 8'he1);
    $display("indexed offset test done");
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  initial begin
    #100000;
    num_errors++;
    complete_run();
  end

  initial begin
    rst_b = 1'b0;
    instr_valid = 1'b0;
    instr_word = 16'h0000;
    sw_wr = 1'b0;
    sw_rd = 1'b0;
    sw_addr = 4'h0;
    sw_wdata = 8'h00;
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    test_reset();
    test_or_lit();
    test_or_file();
    test_move();
    test_ptr();
    test_index();
    complete_run();
  end
endmodule // tb
